// ### rtl/uic_cfg.svh
// Address map, field positions, reset values and timing constants of the interrupt and queue control block.
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH
`define UIC_ADDR_HOLD 3'h0
`define UIC_ADDR_IER 3'h1
`define UIC_ADDR_ISR 3'h2
`define UIC_ADDR_LSR 3'h5
`define UIC_ADDR_MSR 3'h6
`define UIC_IER_RX 0
`define UIC_IER_TX 1
`define UIC_IER_LS 2
`define UIC_IER_MS 3
`define UIC_IER_SLEEP 4
`define UIC_IER_XOFF 5
`define UIC_IER_RTS 6
`define UIC_IER_CTS 7
`define UIC_IER_RESET 8'h00
`define UIC_FCR_EN 0
`define UIC_FCR_RXRST 1
`define UIC_CODE_LS 6'h06
`define UIC_CODE_TO 6'h0C
`define UIC_CODE_RX 6'h04
`define UIC_CODE_TX 6'h02
`define UIC_CODE_MS 6'h00
`define UIC_CODE_XOFF 6'h10
`define UIC_CODE_FLOW 6'h20
`define UIC_CODE_NONE 6'h01
`define UIC_TRIG_RESET 6'h01
`define UIC_RX_TRIG0 6'h08
`define UIC_RX_TRIG1 6'h10
`define UIC_RX_TRIG2 6'h18
`define UIC_RX_TRIG3 6'h1C
`define UIC_TX_TRIG0 6'h10
`define UIC_TX_TRIG1 6'h08
`define UIC_TX_TRIG2 6'h18
`define UIC_TX_TRIG3 6'h1E
`define UIC_TO_CHARS 8'h04
`define UIC_TO_BITS 8'h0C
`define UIC_FIFO_DEPTH 16
`endif

// ### rtl/uic_pkg.sv
// Types shared by the interrupt and queue control block.
package uic_pkg;
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } uic_rx_char_t;
    typedef struct packed {
        logic sel;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uic_bus_req_t;
    typedef enum logic [1:0] {
        UIC_SRC_IDLE,
        UIC_SRC_ARMED
    } uic_tx_state_t;
endpackage

// ### rtl/uic_ctrl.sv
// Interrupt enable, prioritised status and receive queue control with its receive FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "uic_cfg.svh"

// --------------------------------------------------------------------------
// Receive FIFO
// --------------------------------------------------------------------------
module uic_fifo #(
    parameter int W = 11,
    parameter int D = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q, rp_q;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];
    assign level = cnt_q;
    always_comb
    begin
        cnt_d = cnt_q;
        if (push && !pop)
            cnt_d = cnt_q + 1'b1;
        else if (pop && !push)
            cnt_d = cnt_q - 1'b1;
    end
    always_ff @(posedge clk)
    begin
        if (!resetn || (ce && flush))
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end
        else if (ce)
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_d;
            in_ready <= cnt_d != (AW+1)'(D);
        end
    end
    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem_q[wp_q] <= in_data;
    end
endmodule

// --------------------------------------------------------------------------
// Interrupt and queue control
// --------------------------------------------------------------------------
module uic_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Host register bus
    input wire uic_pkg::uic_bus_req_t bus_req,
    output logic [7:0] rd_data,
    // Receiver
    input wire logic rx_valid,
    input wire uic_pkg::uic_rx_char_t rx_char,
    output logic rx_ready,
    input wire logic overrun_event,
    input wire logic [3:0] char_bits,
    input wire logic bit_tick,
    // Transmitter
    input wire logic [5:0] tx_level,
    input wire logic thr_empty,
    input wire logic tsr_empty,
    input wire logic rs485_auto,
    output logic thr_write,
    output logic [7:0] thr_data,
    // Modem and flow control
    input wire logic [7:0] msr_value,
    output logic msr_read,
    input wire logic efr_enable,
    input wire logic xfr_lsr_mode,
    input wire logic auto_rts_en,
    input wire logic auto_cts_en,
    input wire logic rts_level,
    input wire logic cts_level,
    input wire logic xoff_detect,
    input wire logic xon_detect,
    input wire logic special_detect,
    input wire logic char_received,
    input wire logic wake_event,
    // Status outputs
    output logic sleep_enable,
    output logic fifo_enabled,
    output logic irq
);
    import uic_pkg::*;

    logic [7:0] ier_q;
    logic fifo_en_q;
    logic [5:0] rx_trig_q, tx_trig_q;
    logic rd_hold, rd_ier, rd_isr, rd_lsr, rd_msr, wr_hold, wr_ier, wr_fcr;
    logic rx_flush, rx_out_valid, head_new_q, rts_q, cts_q, tx_cond_q;
    logic [$clog2(`UIC_FIFO_DEPTH):0] rx_count;
    uic_rx_char_t head;
    logic [5:0] err_cnt_q;
    logic ovr_q, ls_q, to_q, tx_q, ms_w, xoff_q, spc_q, flow_q, wake_q;
    logic [7:0] to_cnt_q, to_limit;
    logic p_ls, p_to, p_rx, p_tx, p_ms, p_xoff, p_flow, any_pend;
    logic [5:0] code;
    logic tx_cond, tx_set, rx_push, rx_pop;

    // ----------------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------------
    always_comb
    begin
        rd_hold = 1'b0;
        rd_ier = 1'b0;
        rd_isr = 1'b0;
        rd_lsr = 1'b0;
        rd_msr = 1'b0;
        wr_hold = 1'b0;
        wr_ier = 1'b0;
        wr_fcr = 1'b0;
        if (!clk_en || !bus_req.sel)
            rd_hold = 1'b0;
        else if (bus_req.addr == `UIC_ADDR_HOLD)
        begin
            rd_hold = bus_req.rd;
            wr_hold = bus_req.wr;
        end
        else if (bus_req.addr == `UIC_ADDR_IER)
        begin
            rd_ier = bus_req.rd;
            wr_ier = bus_req.wr;
        end
        else if (bus_req.addr == `UIC_ADDR_ISR)
        begin
            rd_isr = bus_req.rd;
            wr_fcr = bus_req.wr;
        end
        else if (bus_req.addr == `UIC_ADDR_LSR)
            rd_lsr = bus_req.rd;
        else if (bus_req.addr == `UIC_ADDR_MSR)
            rd_msr = bus_req.rd;
    end

    // ----------------------------------------------------------------------
    // Receive queue
    // ----------------------------------------------------------------------
    assign rx_flush = wr_fcr && bus_req.wdata[`UIC_FCR_EN] && bus_req.wdata[`UIC_FCR_RXRST];
    assign rx_push = rx_valid && rx_ready;
    assign rx_pop = rd_hold && rx_out_valid;

    uic_fifo #(
        .W($bits(uic_rx_char_t)),
        .D(`UIC_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(core_clk),
        .resetn(resetn),
        .ce(clk_en),
        .flush(rx_flush),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .in_data(rx_char),
        .out_valid(rx_out_valid),
        .out_ready(rd_hold),
        .out_data(head),
        .level(rx_count)
    );

    // Errored characters anywhere in the queue are counted so the summary flag needs no scan.
    always_ff @(posedge core_clk)
    begin
        if (!resetn || (clk_en && rx_flush))
            err_cnt_q <= '0;
        else if (clk_en)
            err_cnt_q <= err_cnt_q + 6'(rx_push && (rx_char.brk || rx_char.frm || rx_char.par))
                - 6'(rx_pop && (head.brk || head.frm || head.par));
    end

    // ----------------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            ier_q <= `UIC_IER_RESET;
        else if (wr_ier)
        begin
            ier_q[3:0] <= bus_req.wdata[3:0];
            if (efr_enable)
                ier_q[7:4] <= bus_req.wdata[7:4];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            fifo_en_q <= 1'b0;
            rx_trig_q <= `UIC_TRIG_RESET;
            tx_trig_q <= `UIC_TRIG_RESET;
        end
        else if (wr_fcr)
        begin
            fifo_en_q <= bus_req.wdata[`UIC_FCR_EN];
            if (bus_req.wdata[`UIC_FCR_EN])
            begin
                case (bus_req.wdata[7:6])
                    2'h0: rx_trig_q <= `UIC_RX_TRIG0;
                    2'h1: rx_trig_q <= `UIC_RX_TRIG1;
                    2'h2: rx_trig_q <= `UIC_RX_TRIG2;
                    default: rx_trig_q <= `UIC_RX_TRIG3;
                endcase
                if (efr_enable)
                begin
                    case (bus_req.wdata[5:4])
                        2'h0: tx_trig_q <= `UIC_TX_TRIG0;
                        2'h1: tx_trig_q <= `UIC_TX_TRIG1;
                        2'h2: tx_trig_q <= `UIC_TX_TRIG2;
                        default: tx_trig_q <= `UIC_TX_TRIG3;
                    endcase
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // Interrupt sources
    // ----------------------------------------------------------------------
    // Without FIFOs the receive interrupt asks for one character only; the queue still holds 16.
    assign p_rx = ier_q[`UIC_IER_RX] && (fifo_en_q ? (6'(rx_count) >= rx_trig_q) : rx_out_valid);
    assign tx_cond = (fifo_en_q ? (tx_level < tx_trig_q) : thr_empty) || (rs485_auto && tsr_empty);
    // The enabling write is judged on the new enable bit, because the old one is still low at that edge.
    assign tx_set = (ier_q[`UIC_IER_TX] && tx_cond && !tx_cond_q)
        || (wr_ier && bus_req.wdata[`UIC_IER_TX] && !ier_q[`UIC_IER_TX] && tx_cond);
    assign ms_w = |msr_value[3:0];
    assign p_ls = ier_q[`UIC_IER_LS] && ls_q;
    assign p_to = ier_q[`UIC_IER_RX] && to_q;
    assign p_tx = ier_q[`UIC_IER_TX] && tx_q;
    assign p_ms = ier_q[`UIC_IER_MS] && ms_w;
    assign p_xoff = efr_enable && ier_q[`UIC_IER_XOFF] && (xoff_q || spc_q);
    assign p_flow = efr_enable && flow_q;
    assign any_pend = p_ls || p_to || p_rx || p_tx || p_ms || p_xoff || p_flow;

    always_comb
    begin
        // The wake-up indication takes the first status read after sleep; pending sources show on the next.
        if (wake_q)
            code = `UIC_CODE_NONE;
        else if (p_ls)
            code = `UIC_CODE_LS;
        else if (p_to)
            code = `UIC_CODE_TO;
        else if (p_rx)
            code = `UIC_CODE_RX;
        else if (p_tx)
            code = `UIC_CODE_TX;
        else if (p_ms)
            code = `UIC_CODE_MS;
        else if (p_xoff)
            code = `UIC_CODE_XOFF;
        else if (p_flow)
            code = `UIC_CODE_FLOW;
        else
            code = `UIC_CODE_NONE;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ovr_q <= 1'b0;
            ls_q <= 1'b0;
            head_new_q <= 1'b0;
        end
        else if (clk_en)
        begin
            head_new_q <= rx_pop || (rx_push && !rx_out_valid);
            ovr_q <= overrun_event || (ovr_q && !rd_lsr);
            // Set wins over the clearing read so an error in that cycle is not lost.
            ls_q <= overrun_event || (xfr_lsr_mode && rx_push && (rx_char.brk || rx_char.frm || rx_char.par))
                || (!xfr_lsr_mode && head_new_q && rx_out_valid && (head.brk || head.frm || head.par))
                || (ls_q && !rd_lsr);
        end
    end

    assign to_limit = `UIC_TO_CHARS * 8'(char_bits) + `UIC_TO_BITS;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            to_cnt_q <= '0;
            to_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rx_push || rd_hold || !rx_out_valid)
                to_cnt_q <= '0;
            else if (bit_tick && to_cnt_q != to_limit)
                to_cnt_q <= to_cnt_q + 1'b1;
            if (rd_hold)
                to_q <= 1'b0;
            else if (rx_out_valid && to_cnt_q == to_limit)
                to_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            tx_q <= 1'b0;
            tx_cond_q <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_cond_q <= tx_cond;
            if (tx_set)
                tx_q <= 1'b1;
            else if (wr_hold || (rd_isr && code == `UIC_CODE_TX) || !ier_q[`UIC_IER_TX])
                tx_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            xoff_q <= 1'b0;
            spc_q <= 1'b0;
            flow_q <= 1'b0;
            wake_q <= 1'b0;
            rts_q <= 1'b0;
            cts_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rts_q <= rts_level;
            cts_q <= cts_level;
            xoff_q <= xoff_detect || (xoff_q && !xon_detect && !(rd_isr && code == `UIC_CODE_XOFF));
            spc_q <= special_detect || (spc_q && !char_received && !(rd_isr && code == `UIC_CODE_XOFF));
            flow_q <= (ier_q[`UIC_IER_RTS] && auto_rts_en && rts_level && !rts_q)
                || (ier_q[`UIC_IER_CTS] && auto_cts_en && cts_level && !cts_q) || (flow_q && !rd_msr);
            wake_q <= wake_event || (wake_q && !rd_isr);
        end
    end

    // ----------------------------------------------------------------------
    // Read data and outputs
    // ----------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            rd_data <= '0;
        else if (rd_hold)
            rd_data <= head.data;
        else if (rd_ier)
            rd_data <= ier_q;
        else if (rd_isr)
            rd_data <= {{2{fifo_en_q}}, code};
        else if (rd_lsr)
            rd_data <= {err_cnt_q != '0, thr_empty && tsr_empty, thr_empty, head.brk && rx_out_valid,
                head.frm && rx_out_valid, head.par && rx_out_valid, ovr_q, rx_out_valid};
        else if (rd_msr)
            rd_data <= msr_value;
        else if (clk_en && bus_req.sel && bus_req.rd)
            rd_data <= '0;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            thr_write <= 1'b0;
            thr_data <= '0;
            msr_read <= 1'b0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            thr_write <= wr_hold;
            if (wr_hold)
                thr_data <= bus_req.wdata;
            msr_read <= rd_msr;
            irq <= any_pend;
        end
    end

    assign sleep_enable = ier_q[`UIC_IER_SLEEP];
    assign fifo_enabled = fifo_en_q;

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    isr_pend_bit_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_isr |=> rd_data[0] == (!$past(any_pend) || $past(wake_q))) else $error("status bit zero wrong");
    isr_fifo_bits_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_isr |=> rd_data[7:6] == {2{$past(fifo_en_q)}}) else $error("fifo status bits wrong");
    irq_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
        clk_en && any_pend |=> irq) else $error("interrupt output missed");
    rx_trig_level_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_isr && fifo_en_q && 6'(rx_count) < rx_trig_q |=> rd_data[5:0] != `UIC_CODE_RX)
        else $error("receive interrupt below trigger");
    lsr_ready_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_lsr |=> rd_data[0] == ($past(rx_count) != '0)) else $error("data ready wrong");
    ier_guard_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_ier && !efr_enable |=> $stable(ier_q[7:4])) else $error("guarded enables changed");
    fcr_ignore_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_fcr && !bus_req.wdata[0] |=> $stable(rx_trig_q) && !fifo_en_q) else $error("control bits taken");
    rx_reset_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rx_flush |=> rx_count == '0) else $error("receive reset failed");
    timeout_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        rd_hold |=> !to_q) else $error("timeout not cleared");
    tx_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_hold && !tx_set |=> !tx_q) else $error("transmit interrupt not cleared");
endmodule
`default_nettype wire

// ### verif/uic_host.sv
// Host processor model that drives the register bus of the interrupt and queue control block.
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------------
// Host register bus master
// --------------------------------------------------------------------------
module uic_host (
    // Clock
    input wire logic core_clk,
    // Register bus
    output var uic_pkg::uic_bus_req_t bus_req,
    input wire logic [7:0] rd_data
);
    import uic_pkg::*;

    initial bus_req = '0;

    // Address and data are inverted on release so a stale value can never look like a fresh request.
    task automatic access(input logic rd, input logic [2:0] addr, input logic [7:0] wdata, output logic [7:0] data);
        @(posedge core_clk);
        #1;
        bus_req = '{sel: 1'b1, rd: rd, wr: ~rd, addr: addr, wdata: wdata};
        @(posedge core_clk);
        #1;
        bus_req = '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
        data = rd_data;
    endtask
endmodule

`default_nettype wire

// ### verif/uart_interrupt_and_fifo_control_tb.sv
// Self-checking testbench of the interrupt and queue control block.
`timescale 1ns/100ps
`default_nettype none
`include "uic_cfg.svh"

module uart_interrupt_and_fifo_control_tb;
    import uic_pkg::*;

    // --------------------------------------------------------------------------
    // Signals, instances and helpers
    // --------------------------------------------------------------------------
    logic core_clk;
    logic resetn = 0, clk_en = 1, rx_valid = 0, overrun_event = 0, bit_tick = 0, thr_empty = 0, tsr_empty = 1;
    logic rs485_auto = 0, efr_enable = 0, xfr_lsr_mode = 0, auto_rts_en = 1, auto_cts_en = 1, rts_level = 0;
    logic cts_level = 0, xoff_detect = 0, xon_detect = 0, special_detect = 0, char_received = 0, wake_event = 0;
    logic rx_ready, thr_write, msr_read, sleep_enable, fifo_enabled, irq, fifo_en = 0;
    logic [3:0] char_bits = 4'h8;
    logic [5:0] tx_level = 6'h00;
    logic [7:0] msr_value = 8'h00, rd_data, thr_data, d;
    uic_rx_char_t rx_char = '0;
    uic_bus_req_t bus_req;
    uic_rx_char_t q[$];
    int fails = 0, num_checks = 0;

    uic_ctrl uic_ctrl_i (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .bus_req(bus_req),
        .rd_data(rd_data), .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready),
        .overrun_event(overrun_event), .char_bits(char_bits), .bit_tick(bit_tick), .tx_level(tx_level),
        .thr_empty(thr_empty), .tsr_empty(tsr_empty), .rs485_auto(rs485_auto), .thr_write(thr_write),
        .thr_data(thr_data), .msr_value(msr_value), .msr_read(msr_read), .efr_enable(efr_enable),
        .xfr_lsr_mode(xfr_lsr_mode), .auto_rts_en(auto_rts_en), .auto_cts_en(auto_cts_en),
        .rts_level(rts_level), .cts_level(cts_level), .xoff_detect(xoff_detect), .xon_detect(xon_detect),
        .special_detect(special_detect), .char_received(char_received), .wake_event(wake_event),
        .sleep_enable(sleep_enable), .fifo_enabled(fifo_enabled), .irq(irq));
    uic_host uic_host_i (.core_clk(core_clk), .bus_req(bus_req), .rd_data(rd_data));

    initial
    begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        uic_host_i.access(1'b1, a, 8'h00, v);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        logic [7:0] unused;
        uic_host_i.access(1'b0, a, v, unused);
    endtask
    task automatic expect_rd(input string name, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check(name, v, exp);
    endtask
    task automatic expect_isr(input logic [5:0] code);
        expect_rd("status", `UIC_ADDR_ISR, {fifo_en, fifo_en, code});
    endtask
    // The model follows a write only as far as the enable bit lets the other bits act.
    task automatic qctl(input logic [7:0] v);
        wr(`UIC_ADDR_ISR, v);
        fifo_en = v[`UIC_FCR_EN];
        if (v[`UIC_FCR_EN] && v[`UIC_FCR_RXRST])
            q.delete();
    endtask
    task automatic push(input logic par);
        uic_rx_char_t c;
        c = '{brk: 1'b0, frm: 1'b0, par: par, data: 8'($urandom)};
        @(posedge core_clk);
        #1;
        rx_valid = 1;
        rx_char = c;
        @(posedge core_clk);
        while (rx_ready !== 1'b1)
            @(posedge core_clk);
        #1;
        rx_valid = 0;
        rx_char = uic_rx_char_t'(~c);
        q.push_back(c);
    endtask
    task automatic pop();
        uic_rx_char_t c;
        c = q.pop_front();
        expect_rd("holding", `UIC_ADDR_HOLD, c.data);
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        step(1);
        s = 0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        fails++;
        conclude();
    end

    // --------------------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------------------
    initial
    begin
        void'($urandom(91));
        repeat (16) @(posedge core_clk);
        #1;
        resetn = 1;
        expect_isr(`UIC_CODE_NONE);
        expect_rd("enable", `UIC_ADDR_IER, `UIC_IER_RESET);
        check("irq", irq, 8'h00);
        $display("test reset done");
        wr(`UIC_ADDR_IER, 8'h05);
        push(1'b1);
        step(2);
        check("irq", irq, 8'h01);
        expect_isr(`UIC_CODE_LS);
        rd(`UIC_ADDR_LSR, d);
        check("line", d & 8'h9F, 8'h85);
        expect_isr(`UIC_CODE_RX);
        pop();
        expect_isr(`UIC_CODE_NONE);
        pulse(overrun_event);
        step(1);
        expect_isr(`UIC_CODE_LS);
        rd(`UIC_ADDR_LSR, d);
        check("line", d & 8'h03, 8'h02);
        expect_isr(`UIC_CODE_NONE);
        xfr_lsr_mode = 1;
        push(1'b0);
        push(1'b1);
        step(1);
        expect_isr(`UIC_CODE_LS);
        rd(`UIC_ADDR_LSR, d);
        check("line", d & 8'h9D, 8'h81);
        pop();
        pop();
        xfr_lsr_mode = 0;
        $display("test line status done");
        thr_empty = 1;
        wr(`UIC_ADDR_IER, 8'h02);
        step(2);
        expect_isr(`UIC_CODE_TX);
        expect_isr(`UIC_CODE_NONE);
        thr_empty = 0;
        d = 8'($urandom);
        wr(`UIC_ADDR_HOLD, d);
        check("thr write", thr_write, 8'h01);
        check("thr data", thr_data, d);
        thr_empty = 1;
        step(2);
        expect_isr(`UIC_CODE_TX);
        thr_empty = 0;
        wr(`UIC_ADDR_HOLD, ~d);
        expect_isr(`UIC_CODE_NONE);
        $display("test transmit done");
        wr(`UIC_ADDR_IER, 8'h08);
        msr_value = 8'h01;
        step(2);
        check("irq", irq, 8'h01);
        expect_isr(`UIC_CODE_MS);
        rd(`UIC_ADDR_MSR, d);
        check("modem", d, 8'h01);
        check("modem read", msr_read, 8'h01);
        msr_value = 8'h00;
        step(2);
        check("irq", irq, 8'h00);
        $display("test modem done");
        wr(`UIC_ADDR_IER, 8'hFF);
        expect_rd("enable", `UIC_ADDR_IER, 8'h0F);
        check("sleep", sleep_enable, 8'h00);
        efr_enable = 1;
        wr(`UIC_ADDR_IER, 8'hF0);
        expect_rd("enable", `UIC_ADDR_IER, 8'hF0);
        check("sleep", sleep_enable, 8'h01);
        wr(`UIC_ADDR_IER, 8'hE0);
        rts_level = 1;
        step(2);
        expect_isr(`UIC_CODE_FLOW);
        pulse(xoff_detect);
        expect_isr(`UIC_CODE_XOFF);
        pulse(xoff_detect);
        pulse(xon_detect);
        expect_isr(`UIC_CODE_FLOW);
        pulse(special_detect);
        expect_isr(`UIC_CODE_XOFF);
        expect_isr(`UIC_CODE_FLOW);
        pulse(special_detect);
        pulse(char_received);
        expect_isr(`UIC_CODE_FLOW);
        rd(`UIC_ADDR_MSR, d);
        expect_isr(`UIC_CODE_NONE);
        cts_level = 1;
        step(2);
        pulse(wake_event);
        expect_isr(`UIC_CODE_NONE);
        expect_isr(`UIC_CODE_FLOW);
        rd(`UIC_ADDR_MSR, d);
        step(1);
        check("irq", irq, 8'h00);
        wr(`UIC_ADDR_IER, 8'h00);
        efr_enable = 0;
        $display("test flow done");
        qctl(8'h01);
        expect_isr(`UIC_CODE_NONE);
        wr(`UIC_ADDR_IER, 8'h01);
        for (int i = 1; i <= 16; i++)
        begin
            push(1'b0);
            if (i == 7)
            begin
                step(2);
                check("irq", irq, 8'h00);
            end
            if (i == 8)
                expect_isr(`UIC_CODE_RX);
        end
        check("ready", rx_ready, 8'h00);
        repeat (8) pop();
        step(1);
        check("irq", irq, 8'h01);
        pop();
        step(1);
        check("irq", irq, 8'h00);
        wr(`UIC_ADDR_IER, 8'h00);
        rd(`UIC_ADDR_LSR, d);
        while (d[0] === 1'b1 && q.size() > 0)
        begin
            pop();
            rd(`UIC_ADDR_LSR, d);
        end
        check("left", 8'(q.size()), 8'h00);
        check("line", d & 8'h81, 8'h00);
        $display("test fifo done");
        wr(`UIC_ADDR_IER, 8'h01);
        push(1'b0);
        bit_tick = 1;
        step(30);
        check("irq", irq, 8'h00);
        step(30);
        expect_isr(`UIC_CODE_TO);
        pop();
        expect_isr(`UIC_CODE_NONE);
        bit_tick = 0;
        efr_enable = 1;
        qctl(8'h11);
        tx_level = 6'h08;
        wr(`UIC_ADDR_IER, 8'h02);
        step(2);
        expect_isr(`UIC_CODE_NONE);
        tx_level = 6'h07;
        step(2);
        expect_isr(`UIC_CODE_TX);
        wr(`UIC_ADDR_IER, 8'h01);
        efr_enable = 0;
        repeat (3) push(1'b0);
        qctl(8'h03);
        rd(`UIC_ADDR_LSR, d);
        check("line", d & 8'h01, 8'h00);
        push(1'b0);
        qctl(8'h02);
        rd(`UIC_ADDR_LSR, d);
        check("line", d & 8'h01, 8'h01);
        check("fifo enabled", fifo_enabled, 8'h00);
        pop();
        expect_isr(`UIC_CODE_NONE);
        $display("test queue control done");
        conclude();
    end
endmodule

`default_nettype wire
